// >>> logic/port_nine_map.svh
// register indices, reset values and field positions of the sixteen-bit port
`ifndef PORT_NINE_MAP_SVH
`define PORT_NINE_MAP_SVH
// register indices; byte address is four times the index
`define PORT_DATA_IDX 32'h0ffff450
`define PORT_DIRECTION_IDX 32'h0ffff451
`define PORT_MODE_SELECT_IDX 32'h0ffff452
`define FUNCTION_SELECT_LOW_IDX 32'h0ffff453
`define FUNCTION_SELECT_HIGH_IDX 32'h0ffff454
`define PULLUP_OPTION_IDX 32'h0ffff455
`define FALLING_EDGE_SELECT_UPPER_IDX 32'h0ffff456
`define RISING_EDGE_SELECT_UPPER_IDX 32'h0ffff457
`define EDGE_STATUS_IDX 32'h0ffff458
`define EDGE_CLEAR_IDX 32'h0ffff459
`define EDGE_ENABLE_IDX 32'h0ffff45a
// reset values
`define PORT_DATA_RST 16'h0000
`define PORT_DIRECTION_RST 16'hffff
`define PORT_MODE_SELECT_RST 16'h0000
`define FUNCTION_SELECT_RST 16'h0000
`define PULLUP_OPTION_RST 16'h0000
`define EDGE_SELECT_RST 8'h00
`define EDGE_STATUS_RST 8'h00
// pin positions with fixed control-mode routing
`define PIN_SERIAL_CLOCK 12
`define PIN_INT_FOUR 13
`define PIN_INT_FIVE 14
`define PIN_INT_SIX 15
// upper pins start here
`define UPPER_BASE 8
`endif

// >>> logic/port_nine_pkg.sv
// types and shared helper functions of the sixteen-bit port
package port_nine_pkg;
  typedef enum logic [1:0] {
    fsel_a,
    fsel_b,
    fsel_c,
    fsel_d
  } func_sel_e;
  typedef enum logic [1:0] {
    edge_none,
    edge_rise,
    edge_fall,
    edge_both
  } edge_mode_e;
  // falling select is the high bit, rising select the low bit
  function automatic edge_mode_e edge_mode(input logic fall, input logic rise);
    edge_mode = edge_mode_e'({fall, rise});
  endfunction : edge_mode
  // merge write data into a 16-bit register by byte strobes
  function automatic logic [15:0] strb_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    strb_merge = old;
    if (strb[0]) begin
      strb_merge[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      strb_merge[15:8] = wd[15:8];
    end
  endfunction : strb_merge
endpackage : port_nine_pkg

// >>> logic/edge_detect.sv
// per-bit edge detector for the eight upper pins
`timescale 1ns/1ps
module edge_detect
  import port_nine_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] level,
  input wire logic [7:0] fall_sel,
  input wire logic [7:0] rise_sel,
  output logic [7:0] evt_q
);
  logic [7:0] prev_q;
  logic [7:0] evt_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 8'h00;
    end else begin
      prev_q <= level;
    end
  end

  always_comb begin
    evt_d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      case (edge_mode(fall_sel[i], rise_sel[i]))
        edge_none: evt_d[i] = 1'b0;
        edge_rise: evt_d[i] = level[i] & ~prev_q[i];
        edge_fall: evt_d[i] = ~level[i] & prev_q[i];
        edge_both: evt_d[i] = level[i] ^ prev_q[i];
        default: evt_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 8'h00;
    end else begin
      evt_q <= evt_d;
    end
  end
endmodule : edge_detect

// >>> logic/port_nine.sv
// sixteen-pin general purpose port with pin multiplexer and apb register access
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "port_nine_map.svh"
module port_nine
  import port_nine_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pin_i,
  output logic [15:0] pin_o,
  output logic [15:0] pin_oe,
  output logic [15:0] pullup_en,
  input wire logic [15:0] alt_out_a,
  input wire logic [15:0] alt_out_b,
  input wire logic [15:0] alt_out_c,
  input wire logic [15:0] alt_out_d,
  input wire logic [15:0] alt_oe_a,
  input wire logic [15:0] alt_oe_b,
  input wire logic [15:0] alt_oe_c,
  input wire logic [15:0] alt_oe_d,
  output logic [15:0] alt_in_a,
  output logic [15:0] alt_in_b,
  output logic [15:0] alt_in_c,
  output logic [15:0] alt_in_d,
  input wire logic clock_output_pin,
  input wire logic second_serial_clock_o,
  input wire logic second_serial_clock_oe,
  output logic second_serial_clock_i,
  output logic ext_interrupt_four,
  output logic ext_interrupt_five,
  output logic ext_interrupt_six,
  output logic irq
);
  logic [15:0] sync1_q;
  logic [15:0] pin_lvl_q;
  logic [15:0] port_data_q;
  logic [15:0] port_direction_q;
  logic [15:0] port_mode_select_q;
  logic [15:0] function_select_low_q;
  logic [15:0] function_select_high_q;
  logic [15:0] pullup_option_q;
  logic [7:0] falling_edge_select_upper_q;
  logic [7:0] rising_edge_select_upper_q;
  logic [7:0] edge_status_q;
  logic [7:0] edge_status_d;
  logic [7:0] edge_enable_q;
  logic [7:0] edge_clear;
  logic [7:0] edge_evt;
  logic [7:0] upper_ctrl_lvl;
  logic [15:0] pin_o_d;
  logic [15:0] pin_oe_d;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] idx;

  // index from byte address; low two bits are ignored
  function automatic logic [31:0] word_index(input logic [31:0] a);
    word_index = {2'b00, a[31:2]};
  endfunction : word_index

  // alternate function for one pin from its two select bits
  function automatic logic pick(input func_sel_e s, input logic a, input logic b,
                                input logic c, input logic d);
    case (s)
      fsel_a: pick = a;
      fsel_b: pick = b;
      fsel_c: pick = c;
      fsel_d: pick = d;
      default: pick = a;
    endcase
  endfunction : pick

  function automatic func_sel_e sel_of(input logic hi, input logic lo);
    sel_of = func_sel_e'({hi, lo});
  endfunction : sel_of

  // apb handshake: zero wait states, error on unmapped index
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & hit;
  assign idx = word_index(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = prdata_q;

  always_comb begin
    case (idx)
      `PORT_DATA_IDX,
      `PORT_DIRECTION_IDX,
      `PORT_MODE_SELECT_IDX,
      `FUNCTION_SELECT_LOW_IDX,
      `FUNCTION_SELECT_HIGH_IDX,
      `PULLUP_OPTION_IDX,
      `FALLING_EDGE_SELECT_UPPER_IDX,
      `RISING_EDGE_SELECT_UPPER_IDX,
      `EDGE_STATUS_IDX,
      `EDGE_CLEAR_IDX,
      `EDGE_ENABLE_IDX: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 16'h0000;
      pin_lvl_q <= 16'h0000;
    end else begin
      sync1_q <= pin_i;
      pin_lvl_q <= sync1_q;
    end
  end

  // output latch written whatever the direction; the pin follows only as output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_q <= `PORT_DATA_RST;
    end else if (wr_en && idx == `PORT_DATA_IDX) begin
      port_data_q <= strb_merge(port_data_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_direction_q <= `PORT_DIRECTION_RST;
    end else if (wr_en && idx == `PORT_DIRECTION_IDX) begin
      port_direction_q <= strb_merge(port_direction_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_mode_select_q <= `PORT_MODE_SELECT_RST;
    end else if (wr_en && idx == `PORT_MODE_SELECT_IDX) begin
      port_mode_select_q <= strb_merge(port_mode_select_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_select_low_q <= `FUNCTION_SELECT_RST;
    end else if (wr_en && idx == `FUNCTION_SELECT_LOW_IDX) begin
      function_select_low_q <= strb_merge(function_select_low_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_select_high_q <= `FUNCTION_SELECT_RST;
    end else if (wr_en && idx == `FUNCTION_SELECT_HIGH_IDX) begin
      function_select_high_q <= strb_merge(function_select_high_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_option_q <= `PULLUP_OPTION_RST;
    end else if (wr_en && idx == `PULLUP_OPTION_IDX) begin
      pullup_option_q <= strb_merge(pullup_option_q, pwdata, pstrb);
    end
  end

  // edge selects cover pins 8 to 15 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      falling_edge_select_upper_q <= `EDGE_SELECT_RST;
    end else if (wr_en && idx == `FALLING_EDGE_SELECT_UPPER_IDX && pstrb[0]) begin
      falling_edge_select_upper_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rising_edge_select_upper_q <= `EDGE_SELECT_RST;
    end else if (wr_en && idx == `RISING_EDGE_SELECT_UPPER_IDX && pstrb[0]) begin
      rising_edge_select_upper_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_enable_q <= 8'h00;
    end else if (wr_en && idx == `EDGE_ENABLE_IDX && pstrb[0]) begin
      edge_enable_q <= pwdata[7:0];
    end
  end

  // write-one-to-clear; a new edge in the same cycle wins over the clear
  assign edge_clear = (wr_en && idx == `EDGE_CLEAR_IDX && pstrb[0]) ? pwdata[7:0] : 8'h00;
  assign edge_status_d = (edge_status_q & ~edge_clear) | edge_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_status_q <= `EDGE_STATUS_RST;
    end else begin
      edge_status_q <= edge_status_d;
    end
  end

  assign irq = |(edge_status_q & edge_enable_q);

  // detection sees a pin only in control mode, so leaving control mode with
  // selects still set looks like an edge to the detector
  assign upper_ctrl_lvl = pin_lvl_q[15:8] & port_mode_select_q[15:8];

  edge_detect u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(upper_ctrl_lvl),
    .fall_sel(falling_edge_select_upper_q),
    .rise_sel(rising_edge_select_upper_q),
    .evt_q(edge_evt)
  );

  // pin 13 carries interrupt four also when the clock output is selected
  assign ext_interrupt_four = edge_evt[`PIN_INT_FOUR - `UPPER_BASE];
  assign ext_interrupt_five = edge_evt[`PIN_INT_FIVE - `UPPER_BASE];
  assign ext_interrupt_six = edge_evt[`PIN_INT_SIX - `UPPER_BASE];

  // pin drive: port mode follows latch and direction, control mode the selected function except on pins 12 to 15, which have fixed routing
  always_comb begin
    pin_o_d = 16'h0000;
    pin_oe_d = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (!port_mode_select_q[i]) begin
        pin_o_d[i] = port_data_q[i];
        pin_oe_d[i] = ~port_direction_q[i];
      end else begin
        pin_o_d[i] = pick(sel_of(function_select_high_q[i], function_select_low_q[i]),
                          alt_out_a[i], alt_out_b[i], alt_out_c[i], alt_out_d[i]);
        pin_oe_d[i] = pick(sel_of(function_select_high_q[i], function_select_low_q[i]),
                           alt_oe_a[i], alt_oe_b[i], alt_oe_c[i], alt_oe_d[i]);
      end
    end
    if (port_mode_select_q[`PIN_SERIAL_CLOCK]) begin
      pin_o_d[`PIN_SERIAL_CLOCK] = second_serial_clock_o;
      pin_oe_d[`PIN_SERIAL_CLOCK] = second_serial_clock_oe;
    end
    if (port_mode_select_q[`PIN_INT_FOUR]) begin
      pin_o_d[`PIN_INT_FOUR] = clock_output_pin;
      pin_oe_d[`PIN_INT_FOUR] = sel_of(function_select_high_q[`PIN_INT_FOUR],
                                       function_select_low_q[`PIN_INT_FOUR]) == fsel_c;
    end
    if (port_mode_select_q[`PIN_INT_FIVE]) begin
      pin_o_d[`PIN_INT_FIVE] = 1'b0;
      pin_oe_d[`PIN_INT_FIVE] = 1'b0;
    end
    if (port_mode_select_q[`PIN_INT_SIX]) begin
      pin_o_d[`PIN_INT_SIX] = 1'b0;
      pin_oe_d[`PIN_INT_SIX] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o <= 16'h0000;
      pin_oe <= 16'h0000;
      pullup_en <= 16'h0000;
    end else begin
      pin_o <= pin_o_d;
      pin_oe <= pin_oe_d;
      pullup_en <= pullup_option_q;
    end
  end

  // received levels go to the selected function; pin 12 in control mode also goes to the serial clock input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_in_a <= 16'h0000;
      alt_in_b <= 16'h0000;
      alt_in_c <= 16'h0000;
      alt_in_d <= 16'h0000;
      second_serial_clock_i <= 1'b0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        alt_in_a[i] <= port_mode_select_q[i] & pin_lvl_q[i] &
                       (sel_of(function_select_high_q[i], function_select_low_q[i]) == fsel_a);
        alt_in_b[i] <= port_mode_select_q[i] & pin_lvl_q[i] &
                       (sel_of(function_select_high_q[i], function_select_low_q[i]) == fsel_b);
        alt_in_c[i] <= port_mode_select_q[i] & pin_lvl_q[i] &
                       (sel_of(function_select_high_q[i], function_select_low_q[i]) == fsel_c);
        alt_in_d[i] <= port_mode_select_q[i] & pin_lvl_q[i] &
                       (sel_of(function_select_high_q[i], function_select_low_q[i]) == fsel_d);
      end
      second_serial_clock_i <= port_mode_select_q[`PIN_SERIAL_CLOCK] &
                               pin_lvl_q[`PIN_SERIAL_CLOCK];
    end
  end

  // read data; the data register shows pin levels, not the latch
  always_comb begin
    case (idx)
      `PORT_DATA_IDX: rdata_d = {16'h0000, pin_lvl_q};
      `PORT_DIRECTION_IDX: rdata_d = {16'h0000, port_direction_q};
      `PORT_MODE_SELECT_IDX: rdata_d = {16'h0000, port_mode_select_q};
      `FUNCTION_SELECT_LOW_IDX: rdata_d = {16'h0000, function_select_low_q};
      `FUNCTION_SELECT_HIGH_IDX: rdata_d = {16'h0000, function_select_high_q};
      `PULLUP_OPTION_IDX: rdata_d = {16'h0000, pullup_option_q};
      `FALLING_EDGE_SELECT_UPPER_IDX: rdata_d = {24'h000000, falling_edge_select_upper_q};
      `RISING_EDGE_SELECT_UPPER_IDX: rdata_d = {24'h000000, rising_edge_select_upper_q};
      `EDGE_STATUS_IDX: rdata_d = {24'h000000, edge_status_q};
      `EDGE_ENABLE_IDX: rdata_d = {24'h000000, edge_enable_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // captured at the setup edge so read data comes from a flop in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_q <= rdata_d;
    end
  end
endmodule : port_nine

// >>> test/port_nine_chk.sv
// concurrent checks on the port's bus, pin and edge outputs
`timescale 1ns/1ps
`include "port_nine_map.svh"
module port_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] pin_i,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pullup_en,
  input wire logic ext_interrupt_six,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic [15:0] dir_q, dat_q, mod_q, pu_q, wm;
  logic [7:0] fe_q, re_q, en_q;
  assign wr = psel & penable & pwrite;
  assign wm = {pstrb[1] ? 8'hff : 8'h00, pstrb[0] ? 8'hff : 8'h00};
  function automatic logic [15:0] mrg(input logic [15:0] o);
    mrg = (o & ~wm) | (pwdata[15:0] & wm);
  endfunction : mrg
  // bus-side mirror, so pin checks need no probes into the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= 16'hffff;
      dat_q <= 16'h0000;
      mod_q <= 16'h0000;
      pu_q <= 16'h0000;
      fe_q <= 8'h00;
      re_q <= 8'h00;
      en_q <= 8'h00;
    end else if (wr) begin
      case (paddr[31:2])
        30'h0ffff450: dat_q <= mrg(dat_q);
        30'h0ffff451: dir_q <= mrg(dir_q);
        30'h0ffff452: mod_q <= mrg(mod_q);
        30'h0ffff455: pu_q <= mrg(pu_q);
        30'h0ffff456: fe_q <= pstrb[0] ? pwdata[7:0] : fe_q;
        30'h0ffff457: re_q <= pstrb[0] ? pwdata[7:0] : re_q;
        30'h0ffff45a: en_q <= pstrb[0] ? pwdata[7:0] : en_q;
        default: ;
      endcase
    end
  end
  property p_rdy;
    pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  // the mapped indices form one contiguous run
  property p_err;
    pslverr == (psel && penable && (paddr[31:2] < 30'h0ffff450 || paddr[31:2] > 30'h0ffff45a));
  endproperty
  a_err: assert property (p_err) else $error("error flag mismatch");
  property p_oe;
    ((pin_oe ^ ~$past(dir_q)) & ~$past(mod_q)) == 16'h0000;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable mismatch");
  property p_out;
    ((pin_o ^ $past(dat_q)) & ~$past(mod_q) & pin_oe) == 16'h0000;
  endproperty
  a_out: assert property (p_out) else $error("pin level mismatch");
  property p_pu;
    pullup_en == $past(pu_q);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up mismatch");
  property p_rise;
    $rose(pin_i[15]) && mod_q[15] && re_q[7] |-> ##[1:4] ext_interrupt_six;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_fall;
    $fell(pin_i[15]) && mod_q[15] && fe_q[7] |-> ##[1:4] ext_interrupt_six;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  // the pulse seen now was decided by the selects one cycle back
  property p_none;
    !fe_q[7] && !re_q[7] && !$past(fe_q[7]) && !$past(re_q[7]) |-> !ext_interrupt_six;
  endproperty
  a_none: assert property (p_none) else $error("edge seen while off");
  property p_irq;
    en_q == 8'h00 |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");
  c_six: cover property (ext_interrupt_six);
  c_irq: cover property (irq);
  c_err: cover property (pslverr);
endmodule : port_chk

bind port_nine port_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en),
  .ext_interrupt_six(ext_interrupt_six), .irq(irq));

// >>> test/pin_board.sv
// board model: what the outside world puts on the sixteen pins
`timescale 1ns/1ps
module pin_board (
  input wire logic pclk,
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pullup_en,
  input wire logic [15:0] drv_val,
  input wire logic [15:0] drv_en,
  output logic [15:0] pin_i
);
  logic [15:0] last_q = 16'h0000;
  logic [15:0] float_lvl;
  // a floating pin toggles, so reliance on a stale level shows up
  assign float_lvl = pullup_en | ~last_q;
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en & float_lvl);
  always @(posedge pclk) begin
    last_q <= pin_i;
  end
endmodule : pin_board

// >>> test/sixteen_bit_port_with_pin_mux_bench.sv
// self-checking bench of the sixteen-pin port
`timescale 1ns/1ps
module sixteen_bit_port_with_pin_mux_bench;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, perr, irq, ext_interrupt_four, ext_interrupt_five, ext_interrupt_six;
  logic [15:0] pin_i, pin_o, pin_oe, pullup_en, alt_in_a, alt_in_b, alt_in_c, alt_in_d;
  logic [15:0] alt_out_a = 16'h0, alt_out_b = 16'h0, alt_out_c = 16'h0, alt_out_d = 16'h0;
  logic [15:0] alt_oe_a = 16'h0, alt_oe_b = 16'h0, alt_oe_c = 16'h0, alt_oe_d = 16'h0;
  logic [15:0] drv_val = 16'h1234, drv_en = 16'hffff;
  logic clock_output_pin = 1'h0, second_serial_clock_o = 1'h0, second_serial_clock_oe = 1'h0;
  logic second_serial_clock_i;
  int bad_count = 0, tests_run = 0, cycles = 0;
  localparam logic [29:0] B = 30'h0ffff450;
  port_nine dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en), .alt_out_a(alt_out_a), .alt_out_b(alt_out_b),
    .alt_out_c(alt_out_c), .alt_out_d(alt_out_d), .alt_oe_a(alt_oe_a), .alt_oe_b(alt_oe_b),
    .alt_oe_c(alt_oe_c), .alt_oe_d(alt_oe_d), .alt_in_a(alt_in_a), .alt_in_b(alt_in_b),
    .alt_in_c(alt_in_c), .alt_in_d(alt_in_d), .clock_output_pin(clock_output_pin),
    .second_serial_clock_o(second_serial_clock_o), .second_serial_clock_oe(second_serial_clock_oe),
    .second_serial_clock_i(second_serial_clock_i), .ext_interrupt_four(ext_interrupt_four),
    .ext_interrupt_five(ext_interrupt_five), .ext_interrupt_six(ext_interrupt_six), .irq(irq));
  pin_board board (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .drv_val(drv_val), .drv_en(drv_en), .pin_i(pin_i));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  task apb(input logic [29:0] ix, input logic w, input logic [15:0] d, input logic [3:0] s,
           output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    r = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task wr(input int o, input logic [15:0] d);
    logic [31:0] r;
    apb(B + 30'(o), 1'h1, d, 4'h3, r);
  endtask : wr
  task rd(input int o, output logic [31:0] r);
    apb(B + 30'(o), 1'h0, 16'h0, 4'h0, r);
  endtask : rd
  // checks happen 1 ns after an edge, once its updates have landed
  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : settle
  task cnt(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      // pin 15 counts in units, pin 14 in sixteens, pin 13 in 256s
      c += int'(ext_interrupt_six === 1'h1) + 16 * int'(ext_interrupt_five === 1'h1) +
           256 * int'(ext_interrupt_four === 1'h1);
    end
  endtask : cnt
  task t_reset;
    logic [31:0] r;
    for (int o = 1; o < 11; o++) begin
      rd(o, r);
      chk("reset value", (o == 1) ? 32'h0000ffff : 32'h0, r);
    end
  endtask : t_reset
  task t_dir;
    logic [31:0] r;
    wr(0, 16'ha55a);
    wr(1, 16'h00ff);
    settle(2);
    chk("pin_oe", 16'hff00, pin_oe);
    chk("pin_o", 16'ha500, pin_o & 16'hff00);
    settle(3);
    rd(0, r);
    chk("pin read", 16'ha534, r);
  endtask : t_dir
  task t_latch;
    logic [31:0] r;
    wr(1, 16'hffff);
    wr(0, 16'h3c3c);
    settle(2);
    chk("input oe", 16'h0000, pin_oe);
    apb(B, 1'h1, 16'h7e00, 4'h2, r);
    wr(1, 16'h0000);
    settle(2);
    chk("latched", 16'h7e3c, pin_o);
  endtask : t_latch
  task t_pull;
    logic [31:0] r;
    wr(5, 16'h8001);
    wr(1, 16'hffff);
    drv_en <= 16'hfffe;
    settle(5);
    chk("pullup_en", 16'h8001, pullup_en);
    rd(0, r);
    chk("pulled pin", 1'h1, r[0]);
    drv_en <= 16'hffff;
  endtask : t_pull
  task t_bad;
    logic [31:0] r;
    rd(11, r);
    chk("unmapped err", 1'h1, perr);
    chk("unmapped data", 32'h0, r);
    wr(8, 16'h00ff);
    rd(8, r);
    chk("status write", 32'h0, r);
    rd(9, r);
    chk("clear read", 32'h0, r);
  endtask : t_bad
  task t_alt;
    logic lvl;
    alt_oe_a <= 16'hffff;
    alt_oe_b <= 16'hffff;
    alt_oe_c <= 16'hffff;
    alt_out_b <= 16'hffff;
    alt_out_d <= 16'hffff;
    second_serial_clock_o <= 1'h1;
    second_serial_clock_oe <= 1'h1;
    wr(3, 16'hffff);
    wr(4, 16'hffff);
    wr(2, 16'h1020);
    for (int k = 0; k < 4; k++) begin
      wr(3, 16'h1000 | (16'(k & 1) << 5));
      wr(4, 16'h1000 | (16'(k >> 1) << 5));
      settle(6);
      lvl = (k == 3) ? drv_val[5] : k[0];
      chk("alt oe", k != 3, pin_oe[5]);
      chk("alt in", (lvl ? 4'h1 : 4'h0) << k, {alt_in_d[5], alt_in_c[5], alt_in_b[5], alt_in_a[5]});
      if (k != 3) begin
        chk("alt out", k[0], pin_o[5]);
      end
    end
    // pin 13 with select c drives the clock output; both selects go to 1 first
    clock_output_pin <= 1'h1;
    wr(3, 16'h3020);
    wr(4, 16'h3020);
    wr(2, 16'h3020);
    wr(3, 16'h1020);
    settle(2);
    chk("clock out oe", 1'h1, pin_oe[13]);
    chk("clock out level", 1'h1, pin_o[13]);
    chk("serial clock oe", 1'h1, pin_oe[12]);
    chk("serial clock out", 1'h1, pin_o[12]);
    // release and flip the drive, so a stuck enable reads the wrong level
    @(posedge pclk);
    second_serial_clock_oe <= 1'h0;
    second_serial_clock_o <= 1'h0;
    settle(5);
    chk("serial clock in", drv_val[12], second_serial_clock_i);
  endtask : t_alt
  task t_edge;
    logic [31:0] r;
    int c;
    wr(3, 16'hffff);
    wr(4, 16'hffff);
    // pins 12 to 15 in control mode; pin 13 stays an input under select d
    apb(B + 30'h2, 1'h1, 16'hf000, 4'h2, r);
    wr(10, 16'h0080);
    for (int m = 0; m < 4; m++) begin
      wr(6, {8'h0, {3{m[1]}}, 5'h0});
      wr(7, {8'h0, {3{m[0]}}, 5'h0});
      drv_val[15:13] <= 3'h7;
      cnt(10, c);
      chk("rise pulses", m[0] ? 32'h111 : 32'h0, c);
      chk("irq", m[0], irq);
      wr(9, 16'h00e0);
      drv_val[15:13] <= 3'h0;
      cnt(10, c);
      chk("fall pulses", m[1] ? 32'h111 : 32'h0, c);
      wr(9, 16'h00e0);
    end
    wr(10, 16'h0000);
    drv_val[15:13] <= 3'h7;
    cnt(10, c);
    rd(8, r);
    chk("status", 32'he0, r);
    chk("masked irq", 1'h0, irq);
    wr(6, 16'h0000);
    wr(7, 16'h0000);
    drv_val[15:13] <= 3'h0;
    wr(2, 16'h0000);
    cnt(10, c);
    chk("leave pulses", 32'h0, c);
  endtask : t_edge
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_dir();
    t_latch();
    t_pull();
    t_bad();
    t_alt();
    t_edge();
    close_out();
  end
endmodule : sixteen_bit_port_with_pin_mux_bench
